// *** rtl/io_sampling_cfg.svh ***
// Constants for the I/O sampling and line passing block.
// Assumes a 25 MHz clock; included by bare name.
`ifndef IO_SAMPLING_CFG_SVH
`define IO_SAMPLING_CFG_SVH
`define CLK_HZ 25000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define HOLD_UNIT_MS 100
`define BLINK_UNIT_MS 10
`define BLINK_DEFAULT_MS 250
`define RSSI_HOLD_RESET 8'h28
`define RSSI_HOLD_FOREVER 8'hFF
`define BLINK_RESET 8'h00
`define CHANGE_MASK_LEGAL 16'h7FFF
`define REF_RESET 2'h0
`define SLEEP_CYCLES_RESET 16'h0001
`define SERIAL_FWD_RESET 1'b1
`define ADDR_DISABLED 64'hFFFFFFFFFFFFFFFF
`define ADDR_ANY 64'h000000000000FFFF
`define BOUND_ADDR_RESET 64'hFFFFFFFFFFFFFFFF
`define CFG_RSSI_HOLD 5'h00
`define CFG_BLINK 5'h01
`define CFG_INTERVAL 5'h02
`define CFG_CHANGE_MASK 5'h03
`define CFG_ADC_REF 5'h04
`define CFG_SLEEP_CYCLES 5'h05
`define CFG_BOUND_LO 5'h06
`define CFG_BOUND_HI 5'h07
`define CFG_SERIAL_FWD 5'h08
`define CFG_TIMEOUT0 5'h10
`endif

// *** rtl/io_sampling_pkg.sv ***
// Types shared by the I/O sampling block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package io_sampling_pkg;
  typedef enum logic [1:0] {SRC_PERIODIC, SRC_FORCED, SRC_CHANGE} sample_src_t;
  typedef enum logic [1:0] {ROUTE_RADIO, ROUTE_SERIAL, ROUTE_REMOTE_RESP} sample_route_t;
  typedef struct packed {
    logic valid;
    logic error;
    sample_src_t src;
    sample_route_t route;
    logic analog_included;
    logic [14:0] digital;
  } sample_t;
  typedef struct packed {
    logic valid;
    logic [63:0] src_addr;
    logic [9:0] present;
    logic [9:0] levels;
  } rx_sample_t;
endpackage

// *** rtl/io_sampling_line_passing.sv ***
// I/O housekeeping: RSSI PWM hold, join LED blink, sample generation and
// output line passing with per-line timeouts.
// Assumes settings arrive as an indexed write strobe; line pins are asynchronous.
//
// Notes on behaviour
// RL1: PWM output held for hold time in 100 ms units, reset 0x28.
// RL2: Each received packet refreshes duty; output stops when hold timer expires.
// RL3: Hold time code 0xFF keeps the PWM output on permanently.
// RL4: Blink setting zero gives 250 ms on and 250 ms off.
// RL5: Nonzero blink setting times 10 ms gives on and off times.
// RL6: Blink applies only when pin has join function and device joined.
// RL7: No sample is produced unless some line is input or output.
// RL8: Forced sample taken at once; local to serial, remote as response.
// RL9: Forced sample with no valid line answers with an error.
// RL10: Nonzero interval samples all enabled lines every interval milliseconds.
// RL11: Enabled change-detect line toggling sends a digital sample immediately.
// RL12: With sleep enabled only edges during wake trigger change samples.
// RL13: Change-triggered samples carry digital states only, no analog.
// RL14: Mask bit n watches line n for 0 to 14; bit 15 stays clear.
// RL15: Reference code 0 is 1.25 V, 1 is 2.5 V, 2 is supply.
// RL16: Analog inputs convert at 10-bit resolution.
// RL17: Periodic sampling only on every Nth wake cycle; zero means every cycle.
// RL18: Outputs follow received samples only from bound source with matching input.
// RL19: Bound address all ones disables line passing.
// RL20: Bound address 0xFFFF accepts samples from any sender.
// RL21: Received samples go to serial only when enabled and in API mode.
// RL22: Lines 0 to 9 revert driven value after timeout; zero disables.
// RL23: Each newly applied remote value restarts that line's timeout.
`timescale 1ns/100ps
`default_nettype none
`include "io_sampling_cfg.svh"
module io_sampling_line_passing #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned ADC_BITS = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_wr_i,
  input wire logic [4:0] cfg_idx_i,
  input wire logic [31:0] cfg_data_i,
  input wire logic [14:0] line_pins_i,
  input wire logic [14:0] line_is_input_i,
  input wire logic [9:0] line_is_output_i,
  input wire logic [9:0] line_cfg_level_i,
  input wire logic join_pin_config_i,
  input wire logic joined_i,
  input wire logic sleep_enabled_i,
  input wire logic awake_i,
  input wire logic wake_start_i,
  input wire logic api_mode_i,
  input wire logic sample_now_cmd_i,
  input wire logic sample_now_remote_i,
  input wire logic rx_packet_i,
  input wire logic [ADC_BITS-1:0] rx_rssi_duty_i,
  input wire io_sampling_pkg::rx_sample_t rx_sample_i,
  output io_sampling_pkg::sample_t sample_o,
  output logic fwd_to_serial_o,
  output logic [9:0] line_out_o,
  output logic rssi_pwm_en_o,
  output logic [ADC_BITS-1:0] rssi_duty_o,
  output logic join_led_o,
  output logic [1:0] adc_ref_o
);
  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  logic [7:0] rssi_pwm_hold_time_reg;
  logic [7:0] link_led_blink_time_reg;
  logic [15:0] periodic_sample_interval_reg;
  logic [15:0] change_detect_mask_reg;
  logic [1:0] adc_reference_select_reg;
  logic [15:0] sleep_cycles_per_sample_reg;
  logic [63:0] bound_source_address_reg;
  logic sample_to_serial_enable_reg;
  logic [15:0] timeout_reg [10];

  // Settings are stored as written, bar bit 15 of the change mask; out-of-range codes are the host's concern.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rssi_pwm_hold_time_reg <= `RSSI_HOLD_RESET; // [RL1]
      link_led_blink_time_reg <= `BLINK_RESET;
      periodic_sample_interval_reg <= 16'h0000;
      change_detect_mask_reg <= 16'h0000;
      adc_reference_select_reg <= `REF_RESET; // [RL15]
      sleep_cycles_per_sample_reg <= `SLEEP_CYCLES_RESET;
      bound_source_address_reg <= `BOUND_ADDR_RESET;
      sample_to_serial_enable_reg <= `SERIAL_FWD_RESET;
    end
    else if (cfg_wr_i)
    begin
      if (cfg_idx_i == `CFG_RSSI_HOLD)
        rssi_pwm_hold_time_reg <= cfg_data_i[7:0];
      else if (cfg_idx_i == `CFG_BLINK)
        link_led_blink_time_reg <= cfg_data_i[7:0];
      else if (cfg_idx_i == `CFG_INTERVAL)
        periodic_sample_interval_reg <= cfg_data_i[15:0];
      else if (cfg_idx_i == `CFG_CHANGE_MASK)
        change_detect_mask_reg <= cfg_data_i[15:0] & `CHANGE_MASK_LEGAL; // [RL14]
      else if (cfg_idx_i == `CFG_ADC_REF)
        adc_reference_select_reg <= cfg_data_i[1:0];
      else if (cfg_idx_i == `CFG_SLEEP_CYCLES)
        sleep_cycles_per_sample_reg <= cfg_data_i[15:0];
      else if (cfg_idx_i == `CFG_BOUND_LO)
        bound_source_address_reg[31:0] <= cfg_data_i;
      else if (cfg_idx_i == `CFG_BOUND_HI)
        bound_source_address_reg[63:32] <= cfg_data_i;
      else if (cfg_idx_i == `CFG_SERIAL_FWD)
        sample_to_serial_enable_reg <= cfg_data_i[0];
    end
  end

  // Timeout settings, one per passed line.
    for (genvar gi = 0; gi < 10; gi++)
    begin : g_tcfg
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          timeout_reg[gi] <= 16'h0000;
        else if (cfg_wr_i && cfg_idx_i == (`CFG_TIMEOUT0 + 5'(gi)))
          timeout_reg[gi] <= cfg_data_i[15:0];
      end
    end

  // The reference code reaches the converter through one register stage. [RL15]
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      adc_ref_o <= `REF_RESET;
    else
      adc_ref_o <= adc_reference_select_reg;
  end

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  logic ms_tick;
  logic [6:0] ms100_cnt_reg;
  logic tick100;
  logic [3:0] ms10_cnt_reg;
  logic tick10;

  // One millisecond enable; the slower units derive from it.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt_reg <= 32'h00000000;
    else if (ms_tick)
      tick_cnt_reg <= 32'h00000000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
  end
  assign ms_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ms100_cnt_reg <= 7'h00;
      ms10_cnt_reg <= 4'h0;
    end
    else if (ms_tick)
    begin
      ms100_cnt_reg <= tick100 ? 7'h00 : ms100_cnt_reg + 7'h01;
      ms10_cnt_reg <= tick10 ? 4'h0 : ms10_cnt_reg + 4'h1;
    end
  end
  assign tick100 = ms_tick && (ms100_cnt_reg == 7'(`HOLD_UNIT_MS - 1));
  assign tick10 = ms_tick && (ms10_cnt_reg == 4'(`BLINK_UNIT_MS - 1));

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [14:0] pins_meta_reg;
  logic [14:0] pins_sync_reg;
  logic [14:0] pins_prev_reg;

  // Two flops before any logic looks at a pin; a third keeps the old level.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pins_meta_reg <= 15'h0000;
      pins_sync_reg <= 15'h0000;
      pins_prev_reg <= 15'h0000;
    end
    else
    begin
      pins_meta_reg <= line_pins_i;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  // ----------------------------------------------------------------------
  // RSSI PWM hold
  // ----------------------------------------------------------------------
  logic [7:0] rssi_left_reg;

  // Each packet reloads duty and hold count; code 0xFF never expires.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rssi_left_reg <= 8'h00;
      rssi_pwm_en_o <= 1'b0;
      rssi_duty_o <= '0;
    end
    else if (rx_packet_i)
    begin
      rssi_duty_o <= rx_rssi_duty_i; // [RL2]
      rssi_left_reg <= rssi_pwm_hold_time_reg; // [RL1]
      rssi_pwm_en_o <= (rssi_pwm_hold_time_reg != 8'h00);
    end
    else if (rssi_pwm_hold_time_reg == `RSSI_HOLD_FOREVER)
      rssi_pwm_en_o <= rssi_pwm_en_o; // [RL3]
    else if (tick100 && rssi_left_reg != 8'h00)
    begin
      rssi_left_reg <= rssi_left_reg - 8'h01;
      if (rssi_left_reg == 8'h01)
        rssi_pwm_en_o <= 1'b0; // [RL2]
    end
  end

  // ----------------------------------------------------------------------
  // Join indicator blink
  // ----------------------------------------------------------------------
  logic [7:0] blink_cnt_reg;
  logic [7:0] blink_half;

  // A zero setting falls back to 25 units of 10 ms.
  assign blink_half = (link_led_blink_time_reg == 8'h00) ? 8'(`BLINK_DEFAULT_MS / `BLINK_UNIT_MS)
                                                         : link_led_blink_time_reg; // [RL4] [RL5]

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      blink_cnt_reg <= 8'h00;
      join_led_o <= 1'b0;
    end
    else if (!(join_pin_config_i && joined_i))
    begin
      blink_cnt_reg <= 8'h00; // [RL6]
      join_led_o <= 1'b0;
    end
    else if (tick10)
    begin
      if (blink_cnt_reg + 8'h01 >= blink_half)
      begin
        blink_cnt_reg <= 8'h00;
        join_led_o <= ~join_led_o; // [RL5]
      end
      else
        blink_cnt_reg <= blink_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Sample generation
  // ----------------------------------------------------------------------
  logic any_valid;
  logic [14:0] change_hit;
  logic [15:0] interval_cnt_reg;
  logic [15:0] wake_cnt_reg;
  logic sample_window_reg;
  logic periodic_due;

  assign any_valid = (|line_is_input_i) || (|line_is_output_i); // [RL7]
  // Asleep edges are dropped because only awake cycles are looked at. [RL12]
  assign change_hit = (pins_sync_reg ^ pins_prev_reg) & change_detect_mask_reg[14:0]
                      & {15{awake_i || !sleep_enabled_i}}; // [RL11] [RL14]

  // Counts wake cycles; every Nth opens the periodic window, zero opens all.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_cnt_reg <= 16'h0000;
      sample_window_reg <= 1'b1;
    end
    else if (!sleep_enabled_i)
      sample_window_reg <= 1'b1;
    else if (wake_start_i)
    begin
      if (sleep_cycles_per_sample_reg <= 16'h0001 ||
          wake_cnt_reg + 16'h0001 >= sleep_cycles_per_sample_reg)
      begin
        wake_cnt_reg <= 16'h0000;
        sample_window_reg <= 1'b1; // [RL17]
      end
      else
      begin
        wake_cnt_reg <= wake_cnt_reg + 16'h0001;
        sample_window_reg <= 1'b0;
      end
    end
  end

  // Interval counter in milliseconds; below-minimum codes are the host's error.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      interval_cnt_reg <= 16'h0000;
    else if (periodic_sample_interval_reg == 16'h0000 || periodic_due)
      interval_cnt_reg <= 16'h0000;
    else if (ms_tick)
      interval_cnt_reg <= interval_cnt_reg + 16'h0001;
  end
  assign periodic_due = ms_tick && (periodic_sample_interval_reg != 16'h0000) &&
                        (interval_cnt_reg + 16'h0001 >= periodic_sample_interval_reg); // [RL10]

  // Forced requests win over change, change over periodic.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sample_o <= '0;
    else
    begin
      sample_o <= '0;
      sample_o.digital <= pins_sync_reg & line_is_input_i;
      if (sample_now_cmd_i || sample_now_remote_i)
      begin
        sample_o.valid <= 1'b1; // [RL8]
        sample_o.error <= !any_valid; // [RL9]
        sample_o.src <= io_sampling_pkg::SRC_FORCED;
        sample_o.route <= sample_now_remote_i ? io_sampling_pkg::ROUTE_REMOTE_RESP
                                              : io_sampling_pkg::ROUTE_SERIAL;
        sample_o.analog_included <= any_valid; // [RL16]
      end
      else if (any_valid && (|change_hit))
      begin
        sample_o.valid <= 1'b1; // [RL11]
        sample_o.src <= io_sampling_pkg::SRC_CHANGE;
        sample_o.route <= io_sampling_pkg::ROUTE_RADIO;
        sample_o.analog_included <= 1'b0; // [RL13]
      end
      else if (any_valid && periodic_due && sample_window_reg && (awake_i || !sleep_enabled_i))
      begin
        sample_o.valid <= 1'b1; // [RL10] [RL17]
        sample_o.src <= io_sampling_pkg::SRC_PERIODIC;
        sample_o.route <= io_sampling_pkg::ROUTE_RADIO;
        sample_o.analog_included <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Received samples: forwarding and line passing
  // ----------------------------------------------------------------------
  logic bind_ok;
  logic [9:0] apply;

  assign bind_ok = rx_sample_i.valid && (bound_source_address_reg != `ADDR_DISABLED) && // [RL19]
                   ((bound_source_address_reg == `ADDR_ANY) || // [RL20]
                    (rx_sample_i.src_addr == bound_source_address_reg)); // [RL18]
  assign apply = {10{bind_ok}} & rx_sample_i.present & line_is_output_i; // [RL18]

  // Forwarding needs both the enable and framed mode.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fwd_to_serial_o <= 1'b0;
    else
      fwd_to_serial_o <= rx_sample_i.valid && sample_to_serial_enable_reg && api_mode_i; // [RL21]
  end

  // Per-line hold counters; a zero timeout keeps the remote value for good.
    for (genvar gi = 0; gi < 10; gi++)
    begin : g_pass
      logic [15:0] left_reg;
      logic driven_reg;
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          left_reg <= 16'h0000;
          driven_reg <= 1'b0;
          line_out_o[gi] <= 1'b0;
        end
        else if (apply[gi])
        begin
          line_out_o[gi] <= rx_sample_i.levels[gi];
          left_reg <= timeout_reg[gi]; // [RL23]
          driven_reg <= 1'b1;
        end
        else if (driven_reg && timeout_reg[gi] != 16'h0000 && tick100)
        begin
          if (left_reg <= 16'h0001)
          begin
            driven_reg <= 1'b0; // [RL22]
            line_out_o[gi] <= line_cfg_level_i[gi];
          end
          else
            left_reg <= left_reg - 16'h0001;
        end
        else if (!driven_reg)
          line_out_o[gi] <= line_cfg_level_i[gi];
      end
    end
endmodule
`default_nettype wire

// *** verification/io_sampling_sva.sv ***
// Port-level checks for the I/O sampling and line passing block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module io_sampling_sva #(
  parameter int unsigned ADC_BITS = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [14:0] line_is_input_i,
  input wire logic [9:0] line_is_output_i,
  input wire logic sleep_enabled_i,
  input wire logic awake_i,
  input wire logic api_mode_i,
  input wire logic sample_now_cmd_i,
  input wire logic sample_now_remote_i,
  input wire logic rx_packet_i,
  input wire logic [ADC_BITS-1:0] rx_rssi_duty_i,
  input wire io_sampling_pkg::rx_sample_t rx_sample_i,
  input wire io_sampling_pkg::sample_t sample_o,
  input wire logic fwd_to_serial_o,
  input wire logic [ADC_BITS-1:0] rssi_duty_o
);
  // ----------------------------------------
  // Sample answers, forwarding and RSSI duty
  // ----------------------------------------
  // All checks share the block clock; reset silences them.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_forced_local: assert property (
    sample_now_cmd_i |=> sample_o.valid && sample_o.src == io_sampling_pkg::SRC_FORCED
      && sample_o.route == io_sampling_pkg::ROUTE_SERIAL) else $error("no local answer");
  a_forced_remote: assert property (
    sample_now_remote_i |=> sample_o.valid && sample_o.route == io_sampling_pkg::ROUTE_REMOTE_RESP)
    else $error("no remote answer");
  a_change_digital_only: assert property (
    sample_o.valid && sample_o.src == io_sampling_pkg::SRC_CHANGE |-> !sample_o.analog_included)
    else $error("analog in change");
  // The wake state counts on the edge that registers the sample.
  a_change_while_awake: assert property (
    sample_o.valid && sample_o.src == io_sampling_pkg::SRC_CHANGE |-> $past(awake_i) || !$past(sleep_enabled_i))
    else $error("change in sleep");
  a_need_some_line: assert property (
    sample_o.valid && !sample_o.error |-> (|$past(line_is_input_i)) || (|$past(line_is_output_i)))
    else $error("no line set");
  a_error_forced_only: assert property (
    sample_o.valid && sample_o.error |-> $past(sample_now_cmd_i) || $past(sample_now_remote_i))
    else $error("stray error");
  a_digital_inputs: assert property (
    sample_o.valid && !sample_o.error |-> (sample_o.digital & ~$past(line_is_input_i)) == 15'h0000)
    else $error("non-input bit");
  a_fwd_cause: assert property (
    fwd_to_serial_o |-> $past(rx_sample_i.valid) && $past(api_mode_i))
    else $error("stray forward");
  a_rssi_duty_load: assert property (
    rx_packet_i |=> rssi_duty_o == $past(rx_rssi_duty_i)) else $error("duty stale");
  c_change: cover property (sample_o.valid && sample_o.src == io_sampling_pkg::SRC_CHANGE);
  c_error: cover property (sample_o.valid && sample_o.error);
  c_fwd: cover property (fwd_to_serial_o);
endmodule
bind io_sampling_line_passing io_sampling_sva #(.ADC_BITS(ADC_BITS)) i_io_sampling_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .line_is_input_i(line_is_input_i), .line_is_output_i(line_is_output_i),
  .sleep_enabled_i(sleep_enabled_i), .awake_i(awake_i), .api_mode_i(api_mode_i),
  .sample_now_cmd_i(sample_now_cmd_i), .sample_now_remote_i(sample_now_remote_i), .rx_packet_i(rx_packet_i),
  .rx_rssi_duty_i(rx_rssi_duty_i), .rx_sample_i(rx_sample_i), .sample_o(sample_o),
  .fwd_to_serial_o(fwd_to_serial_o), .rssi_duty_o(rssi_duty_o));
`default_nettype wire

// *** verification/host_model.sv ***
// Stand-in for the host writing settings and for remote nodes sending samples.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  output logic cfg_wr_o,
  output logic [4:0] cfg_idx_o,
  output logic [31:0] cfg_data_o,
  output io_sampling_pkg::rx_sample_t rx_o
);
  // The idle config bus, and the sample bus after its first use, carry junk, so a stale value is never taken for data.
  initial
  begin
    cfg_wr_o = 1'b0;
    cfg_idx_o = 5'h1F;
    cfg_data_o = 32'hA5A5A5A5;
    rx_o = '0;
  end
  // One setting write; the host never sets bit 15 of the change mask.
  task automatic cfg(input logic [4:0] idx, input logic [31:0] val);
    @(posedge clk_i);
    #1;
    cfg_wr_o = 1'b1;
    cfg_idx_o = idx;
    cfg_data_o = (idx == 5'h03) ? (val & 32'h00007FFF) : val;
    @(posedge clk_i);
    #1;
    cfg_wr_o = 1'b0;
    cfg_data_o = ~cfg_data_o;
  endtask
  // One received sample, valid for a single clock.
  task automatic send(input logic [63:0] adr, input logic [9:0] pres, input logic [9:0] lvl);
    @(posedge clk_i);
    #1;
    rx_o = {1'b1, adr, pres, lvl};
    @(posedge clk_i);
    #1;
    rx_o = {1'b0, ~adr, ~pres, ~lvl};
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the I/O sampling and line passing block.
// Assumes the package is compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  checks++; \
  if ((g) !== (e)) \
  begin \
    num_errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); \
  end
module tb_top;
  localparam int TICK = 10;
  int num_errors = 0;
  int checks = 0;
  int cyc_n = 0;
  int last_per = 0;
  int nper = 0;
  logic [31:0] seed = 32'h0000A0CE;
  logic [31:0] r;
  logic [9:0] lvl;
  logic [63:0] adr = 64'h1122334455667788;
  io_sampling_pkg::sample_t expq[$];
  io_sampling_pkg::sample_t e;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [14:0] pins = 15'h0000;
  logic [14:0] is_in = 15'h0000;
  logic [9:0] is_out = 10'h000;
  logic [9:0] cfg_lvl = 10'h2A5;
  logic jcfg = 1'b0;
  logic joined = 1'b0;
  logic slp = 1'b0;
  logic awake = 1'b1;
  logic wake = 1'b0;
  logic api = 1'b1;
  logic now_l = 1'b0;
  logic now_r = 1'b0;
  logic rxp = 1'b0;
  logic [9:0] duty = 10'h000;
  logic cfg_wr;
  logic [4:0] idx;
  logic [31:0] data;
  io_sampling_pkg::rx_sample_t rx;
  io_sampling_pkg::sample_t smp;
  logic fwd;
  logic [9:0] lout;
  logic pwm;
  logic [9:0] dout;
  logic led;
  logic [1:0] aref;
  io_sampling_line_passing #(.TICK_CYCLES(TICK), .ADC_BITS(10)) i_io_sampling_line_passing (
    .clk_i(clk), .rst_n_i(rst_n), .cfg_wr_i(cfg_wr), .cfg_idx_i(idx), .cfg_data_i(data),
    .line_pins_i(pins), .line_is_input_i(is_in), .line_is_output_i(is_out), .line_cfg_level_i(cfg_lvl),
    .join_pin_config_i(jcfg), .joined_i(joined), .sleep_enabled_i(slp), .awake_i(awake),
    .wake_start_i(wake), .api_mode_i(api), .sample_now_cmd_i(now_l), .sample_now_remote_i(now_r),
    .rx_packet_i(rxp), .rx_rssi_duty_i(duty), .rx_sample_i(rx), .sample_o(smp), .fwd_to_serial_o(fwd),
    .line_out_o(lout), .rssi_pwm_en_o(pwm), .rssi_duty_o(dout), .join_led_o(led), .adc_ref_o(aref));
  host_model i_host_model (.clk_i(clk), .cfg_wr_o(cfg_wr), .cfg_idx_o(idx), .cfg_data_o(data), .rx_o(rx));
  // Free-running 25 MHz clock.
  initial
  begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Waits n edges, then 1 ns more.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic note(input int k, input logic err, input logic [14:0] d);
    expq.push_back({1'b1, err, (k == 2) ? io_sampling_pkg::SRC_CHANGE : io_sampling_pkg::SRC_FORCED,
                    (k == 2) ? io_sampling_pkg::ROUTE_RADIO : (k == 1) ? io_sampling_pkg::ROUTE_REMOTE_RESP :
                    io_sampling_pkg::ROUTE_SERIAL, k != 2, d});
  endtask
  // Cycles until the LED changes, capped at 6000.
  task automatic wchg(output int n);
    logic v;
    v = led;
    n = 0;
    while (led === v && n < 6000)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Periodic samples are timed, all others match the oldest note.
  always @(negedge clk)
  begin
    cyc_n++;
    if (rst_n && smp.valid === 1'b1)
    begin
      if (smp.src === io_sampling_pkg::SRC_PERIODIC)
      begin
        `CHK("periodic digital", pins & is_in, smp.digital)
        if (last_per > 0)
        begin
          `CHK("period", 50 * TICK, cyc_n - last_per)
        end
        last_per = cyc_n;
        nper++;
      end
      else if (expq.size() == 0)
      begin
        `CHK("unexpected sample", 1'b0, smp.valid)
      end
      else
      begin
        e = expq.pop_front();
        if (e.error)
          e.digital = smp.digital;
        if (e.src != io_sampling_pkg::SRC_CHANGE)
          e.analog_included = smp.analog_included;
        `CHK("sample", e, smp)
      end
    end
  end
  // Watchdog, well above the 28k cycles needed.
  initial
  begin
    #(40 * 90000);
    num_errors++;
    $display("FAIL watchdog expected finish seen hang");
    stop_test();
  end
  // Main sequence.
  initial
  begin
    int n;
    cyc(5);
    rst_n = 1'b1;
    `CHK("ref reset", 2'h0, aref)
    `CHK("pwm reset", 1'b0, pwm)
    r = xs();
    pins = r[14:0];
    i_host_model.cfg(5'h02, 32'h00000032);
    `CHK("lines reset", cfg_lvl, lout)
    cyc(1200);
    note(0, 1'b1, 15'h0000);
    now_l = 1'b1;
    cyc(1);
    now_l = 1'b0;
    is_in = 15'h7FFF;
    cyc(1600);
    `CHK("periodic count", 1'b1, nper >= 3)
    i_host_model.cfg(5'h02, 32'h00000000);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      pins = r[14:0];
      cyc(4);
      note(i[0], 1'b0, pins & is_in);
      now_l = ~i[0];
      now_r = i[0];
      cyc(1);
      now_l = 1'b0;
      now_r = 1'b0;
    end
    note(0, 1'b0, pins & is_in);
    note(0, 1'b0, pins & is_in);
    now_l = 1'b1;
    cyc(2);
    now_l = 1'b0;
    i_host_model.cfg(5'h03, 32'h0000FFFF);
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      if (i == 6)
      begin
        slp = 1'b1;
        awake = 1'b0;
      end
      if (i == 7)
      begin
        awake = 1'b1;
        wake = 1'b1;
        cyc(1);
        wake = 1'b0;
      end
      cyc(4);
      pins[r % 15] = ~pins[r % 15];
      if (i != 6)
        note(2, 1'b0, pins & is_in);
      cyc(8);
    end
    slp = 1'b0;
    i_host_model.cfg(5'h03, 32'h00000001);
    pins[5] = ~pins[5];
    cyc(8);
    `CHK("pending samples", 0, expq.size())
    for (int i = 0; i < 3; i++)
    begin
      i_host_model.cfg(5'h04, i);
      cyc(3);
      `CHK("adc ref", i[1:0], aref)
    end
    i_host_model.cfg(5'h00, 32'h00000002);
    r = xs();
    duty = r[9:0];
    rxp = 1'b1;
    cyc(1);
    rxp = 1'b0;
    `CHK("pwm on", 1'b1, pwm)
    `CHK("pwm duty", duty, dout)
    cyc(940);
    `CHK("pwm held", 1'b1, pwm)
    cyc(1160);
    `CHK("pwm expired", 1'b0, pwm)
    i_host_model.cfg(5'h00, 32'h000000FF);
    rxp = 1'b1;
    cyc(1);
    rxp = 1'b0;
    cyc(3000);
    `CHK("pwm forever", 1'b1, pwm)
    jcfg = 1'b1;
    joined = 1'b1;
    wchg(n);
    wchg(n);
    `CHK("blink default", 250 * TICK, n)
    i_host_model.cfg(5'h01, 32'h00000014);
    wchg(n);
    wchg(n);
    `CHK("blink set", 20 * 10 * TICK, n)
    joined = 1'b0;
    cyc(10);
    wchg(n);
    `CHK("blink unjoined", 6000, n)
    is_out = 10'h3FF;
    i_host_model.send(adr, 10'h3FF, ~cfg_lvl);
    `CHK("passing off", cfg_lvl, lout)
    i_host_model.cfg(5'h06, adr[31:0]);
    i_host_model.cfg(5'h07, adr[63:32]);
    i_host_model.send(~adr, 10'h3FF, ~cfg_lvl);
    `CHK("foreign sender", cfg_lvl, lout)
    r = xs();
    lvl = r[9:0];
    i_host_model.send(adr, 10'h0F0, lvl);
    `CHK("bound sender", (lvl & 10'h0F0) | (cfg_lvl & 10'h30F), lout)
    `CHK("forward on", 1'b1, fwd)
    i_host_model.cfg(5'h10, 32'h00000003);
    i_host_model.send(adr, 10'h003, ~cfg_lvl);
    cyc(1500);
    i_host_model.send(adr, 10'h003, ~cfg_lvl);
    cyc(1700);
    `CHK("timeout restarted", ~cfg_lvl[1:0], lout[1:0])
    cyc(1400);
    `CHK("timeout revert", {~cfg_lvl[1], cfg_lvl[0]}, lout[1:0])
    i_host_model.cfg(5'h06, 32'h0000FFFF);
    i_host_model.cfg(5'h07, 32'h00000000);
    lvl = ~lout;
    api = 1'b0;
    i_host_model.send({xs(), xs()}, 10'h300, lvl);
    `CHK("any sender", lvl[9:8], lout[9:8])
    `CHK("forward no api", 1'b0, fwd)
    api = 1'b1;
    i_host_model.cfg(5'h08, 32'h00000000);
    i_host_model.send(adr, 10'h000, lvl);
    `CHK("forward disabled", 1'b0, fwd)
    cyc(5);
    stop_test();
  end
endmodule
`default_nettype wire
